// File: hdl/sdo_upload_pkg.sv
package sdo_upload_pkg;

    // ************************************************************
    // Identifiers and command codes
    // ************************************************************
    localparam logic [10:0] REQ_ID_BASE       = 11'h600;
    localparam logic [10:0] RSP_ID_BASE       = 11'h580;
    localparam logic [7:0]  CMD_INIT_UPLOAD   = 8'h40;
    localparam logic [7:0]  CMD_SEG_REQ       = 8'h60;
    localparam logic [7:0]  CMD_SEG_REQ_MASK  = 8'hEF;
    localparam logic [7:0]  CMD_ABORT         = 8'h80;
    localparam logic [7:0]  CMD_INIT_SEG_RSP  = 8'h41;
    localparam logic [7:0]  CMD_EXP_BASE      = 8'h43;

    // ************************************************************
    // Field positions and counts
    // ************************************************************
    localparam int          TOGGLE_BIT        = 4;
    localparam int          FINAL_BIT         = 0;
    localparam int          UNUSED_LSB        = 1;
    localparam logic [2:0]  SEG_PAYLOAD_BYTES = 3'h7;
    localparam logic [15:0] EXP_MAX_BYTES     = 16'h0004;
    localparam int          FRAME_BYTES       = 8;

    // ************************************************************
    // Abort codes
    // ************************************************************
    localparam logic [31:0] ABORT_TOGGLE      = 32'h05030000;
    localparam logic [31:0] ABORT_CMD_UNKNOWN = 32'h05040001;
    localparam logic [31:0] ABORT_NO_OBJECT   = 32'h06020000;
    localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h06090011;
    localparam logic [31:0] ABORT_GENERAL     = 32'h08000000;

    // ************************************************************
    // Reset values and states
    // ************************************************************
    localparam logic [63:0] FRAME_RESET       = 64'h0;
    localparam logic [15:0] COUNT_RESET       = 16'h0;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h1,
        ST_LOOKUP   = 4'h2,
        ST_SEG_OPEN = 4'h4,
        ST_SEND     = 4'h8
    } state_e;

endpackage : sdo_upload_pkg

// File: hdl/sdo_segment_formatter.sv
`timescale 1ns/100ps
module sdo_segment_formatter
    import sdo_upload_pkg::*;
(
    input  wire logic [15:0] i_remaining,
    input  wire logic        i_toggle,
    input  wire logic [55:0] i_chars,
    output logic      [7:0]  o_cmd,
    output logic      [55:0] o_payload,
    output logic      [2:0]  o_take,
    output logic             o_last
);
    logic [2:0] unused;

    always_comb begin
        o_last = (i_remaining <= {13'h0, SEG_PAYLOAD_BYTES});
        o_take = o_last ? i_remaining[2:0] : SEG_PAYLOAD_BYTES;
        unused = SEG_PAYLOAD_BYTES - o_take;
        o_cmd  = {3'h0, i_toggle, unused, o_last};
        for (int b = 0; b < 7; b++) begin
            // Unused trailing bytes still go out, as zero.
            o_payload[b*8 +: 8] = (b < int'(o_take)) ? i_chars[b*8 +: 8] : 8'h00;
        end
    end

endmodule : sdo_segment_formatter

// File: hdl/sdo_upload_server.sv
`timescale 1ns/100ps
module sdo_upload_server
    import sdo_upload_pkg::*;
#(
    parameter int NODE_ID_WIDTH = 7
) (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rstn,
    input  wire logic [NODE_ID_WIDTH-1:0] i_node_id,
    input  wire logic                     i_rx_valid,
    input  wire logic [10:0]              i_rx_id,
    input  wire logic [63:0]              i_rx_data,
    output logic                          o_tx_valid,
    input  wire logic                     i_tx_ready,
    output logic      [10:0]              o_tx_id,
    output logic      [63:0]              o_tx_data,
    output logic      [15:0]              o_od_index,
    output logic      [7:0]               o_od_subindex,
    input  wire logic                     i_od_found,
    input  wire logic                     i_od_is_string,
    input  wire logic [15:0]              i_od_size,
    input  wire logic [31:0]              i_od_value,
    output logic      [15:0]              o_str_offset,
    input  wire logic [55:0]              i_str_chars
);

    if (NODE_ID_WIDTH < 1 || NODE_ID_WIDTH > 7) begin : g_width_check
        $error("NODE_ID_WIDTH must be between 1 and 7");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        state_e                   st;
        state_e                   ret;
        logic [NODE_ID_WIDTH-1:0] node_s1;
        logic [NODE_ID_WIDTH-1:0] node_s2;
        logic                     toggle;
        logic                     seg_rsp;
        logic [15:0]              object_index;
        logic [7:0]               subidx;
        logic [15:0]              remaining;
        logic [15:0]              offset;
        logic [10:0]              tx_id;
        logic [63:0]              tx_data;
    } server_s;

    server_s r_reg;
    server_s r_next;

    logic        rx_hit;
    logic [7:0]  rx_cmd;
    logic        rx_seg;
    logic        rx_abort;
    logic [7:0]  seg_cmd;
    logic [55:0] seg_payload;
    logic [2:0]  seg_take;
    logic        seg_last;

    function automatic logic [63:0] frame_of(input logic [7:0]  cmd,
                                             input logic [15:0] index,
                                             input logic [7:0]  sub,
                                             input logic [31:0] data);
        return {data, sub, index, cmd};
    endfunction : frame_of

    function automatic logic [31:0] keep_bytes(input logic [31:0] v,
                                               input logic [15:0] n);
        logic [31:0] m;
        m = 32'h0;
        for (int b = 0; b < 4; b++) begin
            if (b < int'(n)) begin
                m[b*8 +: 8] = v[b*8 +: 8];
            end
        end
        return m;
    endfunction : keep_bytes

    sdo_segment_formatter u_fmt (
        .i_remaining (r_reg.remaining),
        .i_toggle    (r_reg.toggle),
        .i_chars     (i_str_chars),
        .o_cmd       (seg_cmd),
        .o_payload   (seg_payload),
        .o_take      (seg_take),
        .o_last      (seg_last)
    );

    assign rx_hit        = i_rx_valid &&
                           (i_rx_id == REQ_ID_BASE + 11'(r_reg.node_s2));
    assign rx_cmd        = i_rx_data[7:0];
    assign rx_seg        = (rx_cmd & CMD_SEG_REQ_MASK) == CMD_SEG_REQ;
    assign rx_abort      = rx_hit && (rx_cmd == CMD_ABORT);
    assign o_tx_valid    = (r_reg.st == ST_SEND);
    assign o_tx_id       = r_reg.tx_id;
    assign o_tx_data     = r_reg.tx_data;
    assign o_od_index    = r_reg.object_index;
    assign o_od_subindex = r_reg.subidx;
    assign o_str_offset  = r_reg.offset;

    // ************************************************************
    // Protocol engine
    // ************************************************************
    always_comb begin
        r_next         = r_reg;
        r_next.node_s1 = i_node_id;
        r_next.node_s2 = r_reg.node_s1;
        r_next.tx_id   = RSP_ID_BASE + 11'(r_reg.node_s2);
        if (rx_abort) begin
            // Any error code is accepted and dropped; nothing is sent back.
            r_next.st = ST_IDLE;
        end else begin
            unique case (r_reg.st)
                ST_IDLE, ST_SEG_OPEN: begin
                    if (rx_hit) begin
                        r_next.st      = ST_SEND;
                        r_next.ret     = ST_IDLE;
                        r_next.seg_rsp = 1'b0;
                        if (rx_cmd == CMD_INIT_UPLOAD) begin
                            r_next.object_index = i_rx_data[23:8];
                            r_next.subidx       = i_rx_data[31:24];
                            r_next.offset       = (i_rx_data[31:24] == 8'h00) ? COUNT_RESET
                                                : {8'h00, i_rx_data[31:24]} - 16'h0001;
                            r_next.st           = ST_LOOKUP;
                        end else if (rx_seg && r_reg.st != ST_SEG_OPEN) begin
                            r_next.tx_data = frame_of(CMD_ABORT, r_reg.object_index,
                                                      r_reg.subidx, ABORT_GENERAL);
                        end else if (rx_seg && rx_cmd[TOGGLE_BIT] != r_reg.toggle) begin
                            r_next.tx_data = frame_of(CMD_ABORT, r_reg.object_index,
                                                      r_reg.subidx, ABORT_TOGGLE);
                        end else if (rx_seg) begin
                            r_next.tx_data   = {seg_payload, seg_cmd};
                            r_next.offset    = r_reg.offset + {13'h0, seg_take};
                            r_next.remaining = r_reg.remaining - {13'h0, seg_take};
                            r_next.toggle    = ~r_reg.toggle;
                            r_next.seg_rsp   = 1'b1;
                            r_next.ret       = seg_last ? ST_IDLE : ST_SEG_OPEN;
                        end else begin
                            r_next.tx_data = frame_of(CMD_ABORT, i_rx_data[23:8],
                                                      i_rx_data[31:24], ABORT_CMD_UNKNOWN);
                        end
                    end
                end
                ST_LOOKUP: begin
                    r_next.st      = ST_SEND;
                    r_next.ret     = ST_IDLE;
                    r_next.seg_rsp = 1'b0;
                    r_next.toggle  = 1'b0;
                    if (!i_od_found) begin
                        r_next.tx_data = frame_of(CMD_ABORT, r_reg.object_index,
                                                  r_reg.subidx, ABORT_NO_OBJECT);
                    end else if (i_od_is_string && r_reg.subidx != 8'h00) begin
                        if ({8'h00, r_reg.subidx} > i_od_size) begin
                            r_next.tx_data = frame_of(CMD_ABORT, r_reg.object_index,
                                                      r_reg.subidx, ABORT_NO_SUBINDEX);
                        end else begin
                            r_next.tx_data = frame_of(8'h4F, r_reg.object_index, r_reg.subidx,
                                                      {24'h0, i_str_chars[7:0]});
                        end
                    end else if (i_od_size != COUNT_RESET && i_od_size <= EXP_MAX_BYTES) begin
                        // Length is coded in bits 3:2 as four minus the byte count.
                        r_next.tx_data = frame_of(CMD_EXP_BASE | {4'h0, 2'(EXP_MAX_BYTES
                                                  - i_od_size), 2'b00},
                                                  r_reg.object_index, r_reg.subidx,
                                                  keep_bytes(i_od_is_string ? i_str_chars[31:0]
                                                  : i_od_value, i_od_size));
                    end else begin
                        r_next.tx_data   = frame_of(CMD_INIT_SEG_RSP, r_reg.object_index,
                                                    r_reg.subidx, {16'h0, i_od_size});
                        r_next.remaining = i_od_size;
                        r_next.offset    = COUNT_RESET;
                        r_next.ret       = ST_SEG_OPEN;
                    end
                end
                ST_SEND: begin
                    // Requests arriving while a response waits are dropped, except an abort, which clears the response.
                    if (i_tx_ready) begin
                        r_next.st = r_reg.ret;
                    end
                end
                default: begin
                    r_next.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r_reg <= '{st: ST_IDLE, ret: ST_IDLE, node_s1: '0, node_s2: '0, toggle: 1'b0,
                       seg_rsp: 1'b0, object_index: COUNT_RESET, subidx: 8'h00,
                       remaining: COUNT_RESET, offset: COUNT_RESET, tx_id: 11'h000,
                       tx_data: FRAME_RESET};
        end else begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence seg_req_s;
        r_reg.st == ST_SEG_OPEN && rx_hit && rx_seg;
    endsequence

    sequence seg_ok_s;
        seg_req_s and (rx_cmd[TOGGLE_BIT] == r_reg.toggle);
    endsequence

    rsp_id_a: assert property (o_tx_valid |-> o_tx_id == RSP_ID_BASE + 11'(r_reg.node_s2))
        else $error("response identifier wrong");
    abort_silent_a: assert property (rx_abort |=> !o_tx_valid)
        else $error("abort was answered");
    toggle_error_a: assert property (seg_req_s and (rx_cmd[TOGGLE_BIT] != r_reg.toggle)
        |=> o_tx_valid && o_tx_data[7:0] == CMD_ABORT && o_tx_data[63:32] == ABORT_TOGGLE)
        else $error("repeated toggle not aborted");
    seg_echo_a: assert property (seg_ok_s |=> o_tx_valid && o_tx_data[7:5] == 3'h0
        && o_tx_data[TOGGLE_BIT] == $past(rx_cmd[TOGGLE_BIT]))
        else $error("segment toggle not echoed");
    stray_seg_a: assert property (r_reg.st == ST_IDLE && rx_hit && rx_seg
        |=> o_tx_data[7:0] == CMD_ABORT && o_tx_data[63:32] == ABORT_GENERAL)
        else $error("stray segment request not aborted");
    init_toggle_a: assert property (r_reg.st == ST_LOOKUP && !rx_abort |=> !r_reg.toggle)
        else $error("toggle not cleared at transfer start");
    two_byte_a: assert property (r_reg.st == ST_LOOKUP && !rx_abort && i_od_found
        && !i_od_is_string && i_od_size == 16'h0002 |=> o_tx_data[7:0] == 8'h4B
        && o_tx_data[47:32] == $past(i_od_value[15:0]) && o_tx_data[63:48] == 16'h0)
        else $error("two byte expedited response wrong");
    long_init_a: assert property (r_reg.st == ST_LOOKUP && !rx_abort && i_od_found
        && i_od_size > 16'h0004 && !(i_od_is_string && r_reg.subidx != 8'h00)
        |=> o_tx_data[7:0] == CMD_INIT_SEG_RSP && o_tx_data[47:32] == $past(i_od_size)
        && o_tx_data[31:8] == {$past(r_reg.subidx), $past(r_reg.object_index)})
        else $error("segmented init response wrong");
    last_seg_a: assert property (o_tx_valid && i_tx_ready && r_reg.seg_rsp
        && o_tx_data[FINAL_BIT] |=> r_reg.st == ST_IDLE)
        else $error("transfer still open after last segment");

endmodule : sdo_upload_server

// File: bench/sdo_od_model.sv
`timescale 1ns/100ps
module sdo_od_model
    import sdo_upload_pkg::*;
(
    input  wire logic [15:0] i_index,
    input  wire logic [7:0]  i_sub,
    input  wire logic [15:0] i_offset,
    output logic             o_found,
    output logic             o_is_string,
    output logic      [15:0] o_size,
    output logic      [31:0] o_value,
    output logic      [55:0] o_chars
);
    // ********
    // Object table
    // ********
    // String bytes are letters from 41h on. Bytes past the end change with
    // the offset, so a design that lets them through is caught.
    always_comb begin
        o_found     = 1'b1;
        o_is_string = 1'b0;
        o_size      = 16'h0000;
        o_value     = 32'h0000_0000;
        case (i_index)
            16'h100A: begin
                o_is_string = 1'b1;
                o_size      = 16'h0011;
            end
            16'h2000: begin
                o_is_string = 1'b1;
                o_size      = 16'h0003;
            end
            16'h6041: begin
                o_size  = 16'h0002;
                o_value = 32'h0000_0240;
            end
            16'h2002: begin
                o_is_string = 1'b1;
                o_size      = 16'h0007;
            end
            16'h2001: begin
                o_size  = 16'h0004;
                o_value = 32'h1122_3344;
            end
            default: o_found = 1'b0;
        endcase
        for (int k = 0; k < 7; k++) begin
            if (32'(i_offset) + k < 32'(o_size)) begin
                o_chars[8*k +: 8] = 8'h41 + i_offset[7:0] + 8'(k);
            end else begin
                o_chars[8*k +: 8] = 8'hA5 ^ i_offset[7:0] ^ i_sub;
            end
        end
    end
endmodule : sdo_od_model

// File: bench/sdo_segmented_upload_server_tb.sv
`timescale 1ns/100ps
module sdo_segmented_upload_server_tb
    import sdo_upload_pkg::*;
();
    localparam logic [10:0] NODE = 11'h003;
    logic        clk;
    logic        rstn;
    logic        rx_valid;
    logic [10:0] rx_id;
    logic [63:0] rx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic [10:0] tx_id;
    logic [63:0] tx_data;
    logic [15:0] od_index;
    logic [7:0]  od_sub;
    logic        od_found;
    logic        od_str;
    logic [15:0] od_size;
    logic [31:0] od_value;
    logic [15:0] str_off;
    logic [55:0] str_chars;
    int          n_mismatch = 0;
    int          num_checks = 0;

    sdo_upload_server i_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_node_id(NODE[6:0]),
        .i_rx_valid(rx_valid), .i_rx_id(rx_id), .i_rx_data(rx_data), .o_tx_valid(tx_valid),
        .i_tx_ready(tx_ready), .o_tx_id(tx_id), .o_tx_data(tx_data), .o_od_index(od_index),
        .o_od_subindex(od_sub), .i_od_found(od_found), .i_od_is_string(od_str),
        .i_od_size(od_size), .i_od_value(od_value), .o_str_offset(str_off),
        .i_str_chars(str_chars));
    sdo_od_model i_od (.i_index(od_index), .i_sub(od_sub), .i_offset(str_off),
        .o_found(od_found), .o_is_string(od_str), .o_size(od_size), .o_value(od_value),
        .o_chars(str_chars));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ********
    // Access tasks
    // ********
    task automatic end_sim();
        $display("mismatches %0d, checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [63:0] frm(input logic [7:0] cmd, input logic [15:0] index,
                                        input logic [7:0] sub, input logic [31:0] dat);
        return {dat, sub, index, cmd};
    endfunction : frm

    function automatic logic [63:0] seg(input logic [7:0] cmd, input int first, input int n);
        logic [63:0] f;
        f = {56'h0, cmd};
        for (int k = 0; k < n; k++) begin
            f[8*k+8 +: 8] = 8'h41 + 8'(first + k);
        end
        return f;
    endfunction : seg

    // Called just after an edge; the frame is taken at the next edge.
    task automatic send(input logic [7:0] cmd, input logic [15:0] index, input logic [7:0] sub,
                        input logic [31:0] dat, input logic [10:0] id = REQ_ID_BASE + NODE);
        rx_id    = id;
        rx_data  = {dat, sub, index, cmd};
        rx_valid = 1'b1;
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask : send

    // The stall holds ready low for a while, so the frame has to stand.
    task automatic get(input logic [63:0] exp, input int stall);
        int n;
        n = 0;
        while (tx_valid !== 1'b1) begin
            if (n == 20) begin
                n_mismatch++;
                $display("wrong value at %0t: no response", $time);
                end_sim();
            end
            n++;
            @(posedge clk);
            #1;
        end
        repeat (stall) begin
            @(posedge clk);
            #1;
        end
        check(64'(tx_id), 64'(RSP_ID_BASE + NODE));
        check(tx_data, exp);
        tx_ready = 1'b1;
        @(posedge clk);
        #1;
        tx_ready = 1'b0;
    endtask : get

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            check({63'h0, tx_valid}, 64'h0);
        end
    endtask : quiet

    task automatic open_str();
        send(CMD_INIT_UPLOAD, 16'h100A, 8'h00, 32'h0);
        get(frm(CMD_INIT_SEG_RSP, 16'h100A, 8'h00, 32'h11), 3);
        send(8'h60, 16'h100A, 8'h00, 32'h0);
        get(seg(8'h00, 0, 7), 0);
    endtask : open_str

    // ********
    // Scenarios
    // ********
    initial begin
        rstn     = 1'b0;
        rx_valid = 1'b0;
        rx_id    = 11'h000;
        rx_data  = 64'h0;
        tx_ready = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        check({63'h0, tx_valid}, 64'h0);
        check(tx_data, 64'h0);
        rstn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        send(CMD_INIT_UPLOAD, 16'h6041, 8'h00, 32'h0);
        get(frm(8'h4B, 16'h6041, 8'h00, 32'h0240), 0);
        send(CMD_INIT_UPLOAD, 16'h100A, 8'h05, 32'h0);
        get(frm(8'h4F, 16'h100A, 8'h05, 32'h45), 0);
        send(CMD_INIT_UPLOAD, 16'h100A, 8'h11, 32'h0);
        get(frm(8'h4F, 16'h100A, 8'h11, 32'h51), 0);
        send(CMD_INIT_UPLOAD, 16'h100A, 8'h12, 32'h0);
        get(frm(CMD_ABORT, 16'h100A, 8'h12, ABORT_NO_SUBINDEX), 0);
        send(CMD_INIT_UPLOAD, 16'h2000, 8'h00, 32'h0);
        get(frm(8'h47, 16'h2000, 8'h00, 32'h43_4241), 0);
        send(CMD_INIT_UPLOAD, 16'h2001, 8'h00, 32'h0);
        get(frm(8'h43, 16'h2001, 8'h00, 32'h1122_3344), 0);
        send(CMD_INIT_UPLOAD, 16'h2002, 8'h00, 32'h0);
        get(frm(CMD_INIT_SEG_RSP, 16'h2002, 8'h00, 32'h7), 0);
        send(8'h60, 16'h2002, 8'h00, 32'h0);
        get(seg(8'h01, 0, 7), 0);
        open_str();
        send(8'h70, 16'h100A, 8'h00, 32'h0);
        get(seg(8'h10, 7, 7), 2);
        send(8'h60, 16'h100A, 8'h00, 32'h0);
        get(seg(8'h09, 14, 3), 0);
        quiet(4);
        send(8'h70, 16'h100A, 8'h00, 32'h0);
        get(frm(CMD_ABORT, 16'h100A, 8'h00, ABORT_GENERAL), 0);
        open_str();
        send(8'h60, 16'h100A, 8'h00, 32'h0);
        get(frm(CMD_ABORT, 16'h100A, 8'h00, ABORT_TOGGLE), 0);
        open_str();
        send(CMD_ABORT, 16'h100A, 8'h00, 32'hDEAD_BEEF);
        quiet(6);
        send(8'h70, 16'h100A, 8'h00, 32'h0);
        get(frm(CMD_ABORT, 16'h100A, 8'h00, ABORT_GENERAL), 0);
        open_str();
        send(CMD_INIT_UPLOAD, 16'h6041, 8'h00, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        check({63'h0, tx_valid}, 64'h1);
        send(CMD_ABORT, 16'h6041, 8'h00, 32'h0);
        quiet(4);
        send(CMD_INIT_UPLOAD, 16'h6041, 8'h00, 32'h0, 11'h604);
        quiet(4);
        send(8'h20, 16'h6041, 8'h01, 32'h0);
        get(frm(CMD_ABORT, 16'h6041, 8'h01, ABORT_CMD_UNKNOWN), 0);
        send(CMD_INIT_UPLOAD, 16'h3000, 8'h00, 32'h0);
        get(frm(CMD_ABORT, 16'h3000, 8'h00, ABORT_NO_OBJECT), 0);
        end_sim();
    end
endmodule : sdo_segmented_upload_server_tb
